// >>> src/eec_counter.sv
`timescale 1ns/1ns
// Notes on behaviour
// - gated mode counts rising edges over 1..65535 ticks of 10 ms, then reports
// - background mode adds one to a running count on every rising edge
// - background starts on start request, stops on request without arguments
// - window above 65535 or below 1 is refused with an error flag
// - enhanced implementation counts edges above 100 kHz correctly
// - input is I/O line 13 on base, line 4 on enhanced
module eec_counter
   import eec_pkg::*;
#(
   parameter int unsigned TICK_CNT = TICK_CYCLES,
   parameter bit          ENHANCED = 1'b1
) (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst,
   // general I/O lines
   input  wire logic [IO_W-1:0]   io_in,
   // gated measurement request
   input  wire logic              gate_start,
   input  wire logic signed [WIN_W-1:0] gate_win,
   output logic                   gate_busy,
   output logic                   gate_done,
   output logic                   gate_err,
   output logic [CNT_W-1:0]       gate_count_q,
   // background counting
   input  wire logic              bg_start,
   input  wire logic              bg_stop,
   output logic                   bg_active,
   output logic [CNT_W-1:0]       bg_count_q
);
   // =====================================================================
   // input select and synchroniser
   // =====================================================================
   localparam logic [3:0] LINE_SEL = ENHANCED ? LINE_ENH : LINE_BASE;
   logic       sync1_q, sync2_q, prev_q;
   logic       rise;
   eec_state_e state_q;
   logic [TICK_W-1:0]   tick_q;
   logic [WIN_W-1:0]    win_q;
   logic [CNT_W-1:0]    acc_q;
   logic                tick_en;
   logic                win_ok;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q  <= 1'b0;
      end else begin
         sync1_q <= io_in[LINE_SEL];
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end
   // at most one edge per two cycles is seen, so any rate well below half the clock counts
   assign rise = sync2_q & ~prev_q;

   // =====================================================================
   // request checking
   // =====================================================================
   assign win_ok = (gate_win >= $signed(WIN_MIN)) && (gate_win <= $signed(WIN_MAX));

   // =====================================================================
   // control state machine
   // =====================================================================
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q <= EEC_IDLE;
      end else begin
         case (state_q)
            EEC_IDLE: begin
               if (bg_start) begin
                  state_q <= EEC_BACK;
               end else if (gate_start && win_ok) begin
                  state_q <= EEC_GATE;
               end
            end
            EEC_GATE: begin
               if (tick_en && win_q == WIN_MIN) begin
                  state_q <= EEC_DONE;
               end
            end
            EEC_DONE: begin
               state_q <= EEC_IDLE;
            end
            EEC_BACK: begin
               if (bg_stop) begin
                  state_q <= EEC_IDLE;
               end
            end
            default: begin
               state_q <= EEC_IDLE;
            end
         endcase
      end
   end

   assign gate_busy = (state_q == EEC_GATE);
   assign bg_active = (state_q == EEC_BACK);

   // =====================================================================
   // 10 ms tick divider and window count
   // =====================================================================
   assign tick_en = gate_busy && (tick_q == TICK_W'(TICK_CNT - 1));

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tick_q <= '0;
         win_q  <= '0;
      end else if (state_q == EEC_IDLE && gate_start && win_ok && !bg_start) begin
         tick_q <= '0;
         win_q  <= gate_win;
      end else if (gate_busy) begin
         tick_q <= tick_en ? '0 : tick_q + 1'b1;
         if (tick_en) begin
            win_q <= win_q - 1'b1;
         end
      end
   end

   // =====================================================================
   // gated accumulator and result
   // =====================================================================
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         acc_q <= '0;
      end else if (state_q == EEC_IDLE && gate_start) begin
         acc_q <= '0;
      end else if (gate_busy && rise) begin
         acc_q <= acc_q + 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gate_count_q <= '0;
         gate_done    <= 1'b0;
         gate_err     <= 1'b0;
      end else begin
         gate_done <= 1'b0;
         if (state_q == EEC_DONE) begin
            gate_count_q <= acc_q;
            gate_done    <= 1'b1;
         end
         if (state_q == EEC_IDLE && gate_start && !bg_start) begin
            gate_err <= !win_ok;
         end else if (gate_start && state_q == EEC_BACK) begin
            gate_err <= 1'b1;
         end
      end
   end

   // =====================================================================
   // background counter
   // =====================================================================
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bg_count_q <= '0;
      end else if (state_q == EEC_IDLE && bg_start) begin
         bg_count_q <= '0;
      end else if (bg_active && rise) begin
         bg_count_q <= bg_count_q + 1'b1;
      end
   end

   // =====================================================================
   // checks
   // =====================================================================
   sequence s_last_tick;
      gate_busy && tick_en && win_q == WIN_MIN;
   endsequence
   property p_done_after;
      @(posedge sys_clk) disable iff (rst) s_last_tick |=> ##1 gate_done;
   endproperty
   a_done_after_window: assert property (p_done_after)
      else $error("result not shown after window end");

   a_bad_win_err: assert property (@(posedge sys_clk) disable iff (rst)
      (state_q == EEC_IDLE && gate_start && !bg_start && !win_ok) |=> gate_err && !gate_busy)
      else $error("bad window not refused");

   a_bg_edge_inc: assert property (@(posedge sys_clk) disable iff (rst)
      (bg_active && rise && !bg_stop) |=> bg_count_q == $past(bg_count_q) + 1)
      else $error("background count missed an edge");

   a_bg_stop_idle: assert property (@(posedge sys_clk) disable iff (rst)
      (bg_active && bg_stop) |=> !bg_active)
      else $error("background not stopped");

   a_bg_start_run: assert property (@(posedge sys_clk) disable iff (rst)
      (state_q == EEC_IDLE && bg_start) |=> bg_active && bg_count_q == 0)
      else $error("background not started");

   a_gate_acc_inc: assert property (@(posedge sys_clk) disable iff (rst)
      (gate_busy && rise) |=> acc_q == $past(acc_q) + 1)
      else $error("gated edge not counted");

   a_gate_clear: assert property (@(posedge sys_clk) disable iff (rst)
      (state_q == EEC_IDLE && gate_start && win_ok && !bg_start) |=> gate_busy && acc_q == 0)
      else $error("accumulator not cleared");

   a_win_decr: assert property (@(posedge sys_clk) disable iff (rst)
      (gate_busy && tick_en) |=> win_q == $past(win_q) - 1)
      else $error("window not stepped");

   a_bg_gate_refused: assert property (@(posedge sys_clk) disable iff (rst)
      (bg_active && gate_start) |=> gate_err && !gate_busy)
      else $error("gated request not refused in background");

   a_done_one_cycle: assert property (@(posedge sys_clk) disable iff (rst)
      gate_done |=> !gate_done)
      else $error("done pulse longer than one cycle");

   a_no_early_done: assert property (@(posedge sys_clk) disable iff (rst)
      gate_busy |-> !gate_done)
      else $error("result shown before window end");

   a_line_sel: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(io_in[LINE_SEL]) |-> ##2 sync2_q)
      else $error("wrong input line");
endmodule // eec_counter

// >>> src/eec_pkg.sv
package eec_pkg;
   // =====================================================================
   // timing
   // =====================================================================
   localparam int unsigned CLK_HZ        = 125_000_000;
   localparam int unsigned TICK_MS       = 10;
   localparam int unsigned TICK_CYCLES   = (CLK_HZ / 1000) * TICK_MS;
   localparam int unsigned TICK_W        = 21;
   // =====================================================================
   // window limits and widths
   // =====================================================================
   localparam int unsigned WIN_W         = 17;
   localparam logic [16:0] WIN_MAX       = 17'h0FFFF;
   localparam logic [16:0] WIN_MIN       = 17'h00001;
   localparam int unsigned CNT_W         = 32;
   // =====================================================================
   // input line selection
   // =====================================================================
   localparam int unsigned IO_W          = 16;
   localparam logic [3:0]  LINE_BASE     = 4'hD;
   localparam logic [3:0]  LINE_ENH      = 4'h4;

   typedef enum logic [3:0] {
      EEC_IDLE  = 4'b0001,
      EEC_GATE  = 4'b0010,
      EEC_DONE  = 4'b0100,
      EEC_BACK  = 4'b1000
   } eec_state_e;
endpackage

// >>> verif/eec_src.sv
`timescale 1ns/1ns
// ======================================================
// external square-wave source on the general I/O lines
// ======================================================
module eec_src
   import eec_pkg::*;
(
   // clock
   input  wire logic            sys_clk,
   // driven lines
   output logic [IO_W-1:0]      io
);
   initial io = '0;

   // n full cycles on one line, idle low between bursts
   // half period is kept well above the sampling limit
   task automatic burst(input logic [3:0] ln, input int n, input int half);
      repeat (2) @(posedge sys_clk);
      repeat (n) begin
         io[ln] <= 1'b1;
         repeat (half) @(posedge sys_clk);
         io[ln] <= 1'b0;
         repeat (half) @(posedge sys_clk);
      end
   endtask
endmodule // eec_src

// >>> verif/test_eec_counter.sv
`timescale 1ns/1ns
module test_eec_counter;
   import eec_pkg::*;
   localparam int TK = 10;
   logic                    sys_clk = 1'b0;
   logic                    rst     = 1'b1;
   logic [IO_W-1:0]         io_in;
   logic                    gate_start = 1'b0;
   logic signed [WIN_W-1:0] gate_win   = '0;
   logic                    bg_start   = 1'b0;
   logic                    bg_stop    = 1'b0;
   logic                    gate_busy, gate_done, gate_err, bg_active;
   logic [CNT_W-1:0]        gate_count_q, bg_count_q;
   int                      miscompares = 0;
   int                      compares    = 0;
   int                      cyc;

   always #4 sys_clk = ~sys_clk;

   eec_src u_eec_src (.sys_clk(sys_clk), .io(io_in));
   eec_counter #(.TICK_CNT(TK), .ENHANCED(1'b1)) u_eec_counter (
      .sys_clk(sys_clk), .rst(rst), .io_in(io_in), .gate_start(gate_start),
      .gate_win(gate_win), .gate_busy(gate_busy), .gate_done(gate_done),
      .gate_err(gate_err), .gate_count_q(gate_count_q), .bg_start(bg_start),
      .bg_stop(bg_stop), .bg_active(bg_active), .bg_count_q(bg_count_q));

   // ======================================================
   // helpers
   // ======================================================
   task conclude();
      if (miscompares == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         $display("Error %s expected %h seen %h", nm, exp, seen);
         miscompares++;
      end
   endtask

   task req_gate(input logic signed [WIN_W-1:0] w);
      @(posedge sys_clk);
      gate_win   <= w;
      gate_start <= 1'b1;
      @(posedge sys_clk);
      gate_start <= 1'b0;
   endtask

   task pulse_bg(input logic go);
      @(posedge sys_clk);
      if (go) bg_start <= 1'b1; else bg_stop <= 1'b1;
      @(posedge sys_clk);
      bg_start <= 1'b0;
      bg_stop  <= 1'b0;
   endtask

   // ======================================================
   // scenarios
   // ======================================================
   task t_gate(input logic [3:0] ln, input int n, input int w, input logic [31:0] exp);
      req_gate(w[WIN_W-1:0]);
      cyc = 0;
      fork
         u_eec_src.burst(ln, n, 2);
         while (cyc < 2000) begin
            @(posedge sys_clk);
            #1 cyc++;
            if (gate_done === 1'b1) break;
         end
      join
      check("done_cycle", cyc, w * TK + 1);
      check("gate_count", gate_count_q, exp);
      check("gate_err", gate_err, 1'b0);
   endtask

   task t_bad(input logic signed [WIN_W-1:0] w);
      req_gate(w);
      repeat (2) @(posedge sys_clk);
      #1 check("bad_err", gate_err, 1'b1);
      check("bad_busy", gate_busy, 1'b0);
   endtask

   task t_back();
      pulse_bg(1'b1);
      #1 check("bg_on", bg_active, 1'b1);
      check("bg_zero", bg_count_q, 32'h0);
      u_eec_src.burst(4'h4, 5, 2);
      repeat (3) @(posedge sys_clk);
      #1 check("bg_count", bg_count_q, 32'h5);
      req_gate(17'sh00003);
      repeat (2) @(posedge sys_clk);
      #1 check("bg_gate_err", gate_err, 1'b1);
      check("bg_gate_busy", gate_busy, 1'b0);
      pulse_bg(1'b0);
      #1 check("bg_off", bg_active, 1'b0);
      u_eec_src.burst(4'h4, 3, 2);
      repeat (3) @(posedge sys_clk);
      #1 check("bg_held", bg_count_q, 32'h5);
   endtask

   // ======================================================
   // main sequence and watchdog
   // ======================================================
   initial begin
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      t_bad(17'sh00000);
      t_bad(-17'sh00001);
      t_gate(4'h4, 4, 3, 32'h4);
      t_gate(4'h4, 0, 1, 32'h0);
      t_gate(4'hD, 4, 3, 32'h0);
      t_back();
      t_gate(4'h4, 6, 4, 32'h6);
      t_back();
      conclude();
   end

   initial begin
      repeat (3000) @(posedge sys_clk);
      miscompares++;
      conclude();
   end
endmodule // test_eec_counter
